// file: hdl/pct_port_timing.sv
// Machine-cycle sequencer and four-port I/O block
`timescale 1ns/1ps
`default_nettype none
`include "pct_cfg.svh"
// Behaviour
// RULE1: Internal clocking at half oscillator rate
// RULE2: Cycle is six states, twelve periods
// RULE3: Each phase one period, state two
// RULE4: Address strobe pulses S1P2-S2P1, S4P2-S5P1
// RULE5: Opcode at S1P2, byte at S4
// RULE6: One-byte op discards S4 byte
// RULE7: Two fetches per cycle, external move skips
// RULE8: Multiply and divide take four cycles
// RULE9: Latch write, latch read, pin read
// RULE10: Alternate function pins on ports one, three
// RULE11: Alternate output only when latch is 1
// RULE12: Port three pins always feed alternates
// RULE13: External access switches port zero, two
// RULE14: External access sets port zero latch
// RULE15: Port two shows address only when wide
// RULE16: Port zero pull-up only in bus ones
// RULE17: Latch one disables pull-down driver
// RULE18: Reset loads all latches with ones
// RULE19: Write at S6P2, pin at S1P1
// RULE20: Strong pull-up at S1 on rise
// RULE21: Strong pull-up two periods, arms hold
// RULE22: Weak pull-up whenever pull-down off
// RULE23: Port two strong while address ones
// RULE24: Modify-write reads latch, not pin
// RULE25: Pull-ups are separate enable outputs
module pct_port_timing (
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_rst_n,
  input  wire logic                     i_op_start,
  input  wire pct_pkg::pct_cls_t        i_op_class,
  input  wire logic                     i_op_two_byte,
  input  wire logic                     i_op_wide_addr,
  input  wire logic [`PCT_PORT_W-1:0]   i_code_byte,
  input  wire pct_pkg::pct_port_t       i_port_sel,
  input  wire logic                     i_wr_req,
  input  wire logic [`PCT_PORT_W-1:0]   i_wr_data,
  input  wire logic                     i_rd_latch,
  input  wire logic                     i_rmw,
  input  wire logic                     i_rd_pin,
  input  wire logic                     i_ext_access,
  input  wire logic [15:0]              i_ext_addr,
  input  wire logic [`PCT_PORT_W-1:0]   i_ext_data_out,
  input  wire logic                     i_ext_data_dir,
  input  wire logic [`PCT_PORT_W-1:0]   i_alt_out_one,
  input  wire logic [`PCT_PORT_W-1:0]   i_alt_out_three,
  input  wire logic [`PCT_PORT_W-1:0]   i_pin_zero,
  input  wire logic [`PCT_PORT_W-1:0]   i_pin_one,
  input  wire logic [`PCT_PORT_W-1:0]   i_pin_two,
  input  wire logic [`PCT_PORT_W-1:0]   i_pin_three,
  output logic                          o_phase1,
  output logic                          o_phase2,
  output logic [2:0]                    o_state,
  output logic                          o_cycle_end,
  output logic                          o_addr_strobe,
  output logic                          o_fetch,
  output logic                          o_pc_incr,
  output logic                          o_op_done,
  output logic [`PCT_PORT_W-1:0]        o_instr_reg,
  output logic [`PCT_PORT_W-1:0]        o_second_byte,
  output logic [`PCT_PORT_W-1:0]        o_rd_data,
  output logic                          o_timer2_count_in,
  output logic                          o_timer2_trigger_in,
  output logic                          o_serial_in,
  output logic                          o_ext_irq_a,
  output logic                          o_ext_irq_b,
  output logic                          o_timer0_count_in,
  output logic                          o_timer1_count_in,
  output logic [`PCT_PORT_W-1:0]        o_ext_data_in,
  output logic [`PCT_PORT_W*4-1:0]      o_pull_down,
  output logic [`PCT_PORT_W*4-1:0]      o_pull_strong,
  output logic [`PCT_PORT_W*4-1:0]      o_pull_hold,
  output logic [`PCT_PORT_W*4-1:0]      o_pull_weak
);
  // One system clock is one oscillator period; each phase lasts one whole clock
  logic [3:0] phase_idx;
  logic [3:0] next_phase_idx;
  logic [1:0] cyc_left;
  logic [1:0] next_cyc_left;
  logic       in_external_data_move;
  logic       next_in_external_data_move;
  logic       one_byte;
  logic       next_one_byte;
  logic [`PCT_PORT_W-1:0] ir;
  logic [`PCT_PORT_W-1:0] next_ir;
  logic [`PCT_PORT_W-1:0] sb;
  logic [`PCT_PORT_W-1:0] next_sb;
  logic [`PCT_PORT_W-1:0] rd_data;
  logic [`PCT_PORT_W-1:0] next_rd_data;
  logic       external_data_move_skip;
  logic       at_end;
  logic       wr_slot;
  logic       s1;
  logic [`PCT_PORT_W*4-1:0] latch_all;
  logic [`PCT_PORT_W*4-1:0] pin_all;
  logic [`PCT_PORT_W*4-1:0] alt_all;
  logic [`PCT_PORT_W*4-1:0] bus_val_all;
  logic [3:0] bus_sel_port;

  always_comb begin
    next_phase_idx = (phase_idx == `PCT_PHASE_LAST) ? 4'h0
                     : phase_idx + 4'h1; // see RULE2 RULE3
  end

  assign at_end      = (phase_idx == `PCT_PH_S6P2); // see RULE5
  // Looks one phase ahead so the strong pull-up can start at S1P1
  assign s1          = (next_phase_idx[3:1] == 3'h0);
  assign o_phase1    = !phase_idx[0]; // see RULE1 RULE3
  assign o_phase2    = phase_idx[0];
  assign o_state     = phase_idx[3:1];
  assign o_cycle_end = at_end;
  // Skipped fetches fall in the second cycle of the external move
  assign external_data_move_skip   = in_external_data_move && (cyc_left == 2'h0); // see RULE7
  assign o_addr_strobe = !(external_data_move_skip && phase_idx <= `PCT_PH_S2P1) &&
    ((phase_idx == `PCT_PH_S1P2) || (phase_idx == `PCT_PH_S2P1) ||
     (phase_idx == `PCT_PH_S4P2) ||
     (phase_idx == `PCT_PH_S5P1)); // see RULE4
  assign o_fetch     = !external_data_move_skip &&
    ((phase_idx == `PCT_PH_S1P2) || (phase_idx == `PCT_PH_S4P2)); // see RULE7
  assign o_pc_incr   = o_fetch &&
    !((phase_idx == `PCT_PH_S4P2) && one_byte); // see RULE6
  assign o_op_done   = at_end && (cyc_left == 2'h0); // see RULE8
  assign wr_slot     = o_op_done && i_wr_req; // see RULE19

  always_comb begin
    next_cyc_left = cyc_left;
    next_in_external_data_move  = in_external_data_move;
    next_one_byte = one_byte;
    next_ir       = ir;
    next_sb       = sb;
    if (phase_idx == `PCT_PH_S1P2 && i_op_start && cyc_left == 2'h0) begin
      next_ir       = i_code_byte; // see RULE5
      next_one_byte = !i_op_two_byte;
      next_in_external_data_move  = (i_op_class == pct_pkg::PCT_EXTERNAL_DATA_MOVE);
      case (i_op_class)
        pct_pkg::PCT_ONE_CYC: next_cyc_left = 2'h0;
        pct_pkg::PCT_TWO_CYC: next_cyc_left = `PCT_EXTERNAL_DATA_MOVE_CYC;
        pct_pkg::PCT_EXTERNAL_DATA_MOVE:    next_cyc_left = `PCT_EXTERNAL_DATA_MOVE_CYC;
        pct_pkg::PCT_MULDIV:  next_cyc_left = `PCT_MULDIV_CYC; // see RULE8
        default:              next_cyc_left = 2'h0;
      endcase
    end else if (at_end && cyc_left != 2'h0) begin
      next_cyc_left = cyc_left - 2'h1;
    end else if (at_end) begin
      next_in_external_data_move = 1'b0;
    end
    if (phase_idx == `PCT_PH_S4P2 && !one_byte && !external_data_move_skip) begin
      next_sb = i_code_byte; // see RULE6
    end
  end

  // Read mux: modify-write and latch reads see the latch, never the pin
  always_comb begin
    next_rd_data = rd_data;
    if (i_rd_latch || i_rmw) begin
      next_rd_data = latch_all[i_port_sel*`PCT_PORT_W +: `PCT_PORT_W]; // see RULE24
    end else if (i_rd_pin) begin
      next_rd_data = pin_all[i_port_sel*`PCT_PORT_W +: `PCT_PORT_W]; // see RULE9
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_idx <= `PCT_PH_S1P1;
      cyc_left  <= 2'h0;
      in_external_data_move   <= 1'b0;
      one_byte  <= 1'b1;
      ir        <= 8'h00;
      sb        <= 8'h00;
      rd_data   <= 8'h00;
    end else begin
      phase_idx <= next_phase_idx;
      cyc_left  <= next_cyc_left;
      in_external_data_move   <= next_in_external_data_move;
      one_byte  <= next_one_byte;
      ir        <= next_ir;
      sb        <= next_sb;
      rd_data   <= next_rd_data;
    end
  end

  assign o_instr_reg   = ir;
  assign o_second_byte = sb;
  assign o_rd_data     = rd_data;

  assign pin_all = {i_pin_three, i_pin_two, i_pin_one, i_pin_zero};
  // Port two takes the bus only for wide addresses
  assign bus_sel_port = {1'b0, i_ext_access && i_op_wide_addr, 1'b0,
                         i_ext_access}; // see RULE13 RULE15
  assign bus_val_all  = {8'hff, i_ext_addr[15:8], 8'hff,
                         i_ext_data_dir ? i_ext_data_out : i_ext_addr[7:0]};
  assign alt_all      = {i_alt_out_three, 8'hff, i_alt_out_one, 8'hff};
  assign o_ext_data_in = i_pin_zero;

  // Alternate inputs take the real pin whatever the latch holds
  assign o_timer2_count_in   = i_pin_one[0]; // see RULE10
  assign o_timer2_trigger_in = i_pin_one[1];
  assign o_serial_in         = i_pin_three[0]; // see RULE12
  assign o_ext_irq_a         = i_pin_three[2];
  assign o_ext_irq_b         = i_pin_three[3];
  assign o_timer0_count_in   = i_pin_three[4];
  assign o_timer1_count_in   = i_pin_three[5];

  genvar g;
  generate
    for (g = 0; g < `PCT_PORT_W*4; g = g + 1) begin : g_bit
      localparam int P = g / `PCT_PORT_W;
      pct_port_bit u_bit (
        .i_clk_sys   (i_clk_sys),
        .i_rst_n     (i_rst_n),
        .i_wr        (wr_slot && (i_port_sel == P[1:0])),
        .i_wr_data   (i_wr_data[g % `PCT_PORT_W]),
        .i_force_one ((P == 0) && i_ext_access), // see RULE14
        .i_phase1    (o_phase1),
        .i_s1        (s1),
        .i_alt_out   (alt_all[g]),
        .i_bus_sel   (bus_sel_port[P]),
        .i_bus_val   (bus_val_all[g]),
        .i_quasi     (P != 0), // see RULE16
        .i_pin       (pin_all[g]),
        .o_latch     (latch_all[g]),
        .o_pull_down (o_pull_down[g]),
        .o_strong    (o_pull_strong[g]),
        .o_hold      (o_pull_hold[g]),
        .o_weak      (o_pull_weak[g])
      );
    end
  endgenerate
endmodule // pct_port_timing
`default_nettype wire

// file: include/pct_cfg.svh
// Constants for the port and machine-cycle timing block
`ifndef PCT_CFG_SVH
`define PCT_CFG_SVH
`define PCT_PORT_W      8
`define PCT_PORT_ONES   8'hff
`define PCT_PHASE_LAST  4'hb
`define PCT_PH_S1P1     4'h0
`define PCT_PH_S1P2     4'h1
`define PCT_PH_S2P1     4'h2
`define PCT_PH_S4P2     4'h7
`define PCT_PH_S5P1     4'h8
`define PCT_PH_S6P2     4'hb
`define PCT_MULDIV_CYC  2'h3
`define PCT_EXTERNAL_DATA_MOVE_CYC    2'h1
`define PCT_STRONG_PER  2'h2
`endif

// file: include/pct_pkg.sv
// Types for the port and machine-cycle timing block
package pct_pkg;
  typedef enum logic [1:0] {
    PCT_ONE_CYC  = 2'h0,
    PCT_TWO_CYC  = 2'h1,
    PCT_EXTERNAL_DATA_MOVE     = 2'h2,
    PCT_MULDIV   = 2'h3
  } pct_cls_t;
  typedef enum logic [1:0] {
    PCT_PORT_ZERO  = 2'h0,
    PCT_PORT_ONE   = 2'h1,
    PCT_PORT_TWO   = 2'h2,
    PCT_PORT_THREE = 2'h3
  } pct_port_t;
endpackage

// file: hdl/pct_port_bit.sv
// One quasi-bidirectional port bit with pull-up sequencing
`timescale 1ns/1ps
`default_nettype none
`include "pct_cfg.svh"
module pct_port_bit (
  input  wire logic i_clk_sys,
  input  wire logic i_rst_n,
  input  wire logic i_wr,
  input  wire logic i_wr_data,
  input  wire logic i_force_one,
  input  wire logic i_phase1,
  input  wire logic i_s1,
  input  wire logic i_alt_out,
  input  wire logic i_bus_sel,
  input  wire logic i_bus_val,
  input  wire logic i_quasi,
  input  wire logic i_pin,
  output logic      o_latch,
  output logic      o_pull_down,
  output logic      o_strong,
  output logic      o_hold,
  output logic      o_weak
);
  logic       latch;
  logic       next_latch;
  logic       buf_q;
  logic       next_buf_q;
  logic [1:0] strong_cnt;
  logic [1:0] next_strong_cnt;
  logic       hold;
  logic       next_hold;
  logic       drive_val;

  always_comb begin
    next_latch = latch;
    if (i_force_one) begin
      next_latch = 1'b1; // see RULE14
    end else if (i_wr) begin
      next_latch = i_wr_data; // see RULE9
    end
    // Buffer loads as phase 1 starts and holds through phase 2, so a
    // write landing at S6P2 reaches the pin during S1P1
    next_buf_q = i_phase1 ? buf_q : next_latch; // see RULE19
    next_strong_cnt = strong_cnt;
    // i_s1 marks that the coming phase lies in state one
    if (i_quasi && !i_phase1 && i_s1 && !buf_q && next_buf_q) begin
      next_strong_cnt = `PCT_STRONG_PER; // see RULE20
    end else if (strong_cnt != 2'h0) begin
      next_strong_cnt = strong_cnt - 2'h1; // see RULE21
    end
    next_hold = hold;
    if (o_strong) begin
      next_hold = 1'b1; // see RULE21
    end else if (!i_pin || o_pull_down) begin
      next_hold = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      latch      <= 1'b1; // see RULE18
      buf_q      <= 1'b1;
      strong_cnt <= 2'h0;
      hold       <= 1'b0;
    end else begin
      latch      <= next_latch;
      buf_q      <= next_buf_q;
      strong_cnt <= next_strong_cnt;
      hold       <= next_hold;
    end
  end

  // Alternate output only passes when the latch holds 1
  assign drive_val   = i_bus_sel ? i_bus_val
                                 : (buf_q & i_alt_out); // see RULE11
  assign o_latch     = latch;
  assign o_pull_down = !drive_val; // see RULE17
  // Bus mode keeps strong pull-up for ones (port zero and two)
  assign o_strong    = (i_bus_sel && i_bus_val)
                       || (strong_cnt != 2'h0); // see RULE16 RULE23
  assign o_hold      = i_quasi && hold && !o_pull_down; // see RULE25
  assign o_weak      = i_quasi && !o_pull_down; // see RULE22
endmodule // pct_port_bit
`default_nettype wire

// file: verif/pct_port_timing_checker.sv
// Concurrent checks on the timing and port block's outputs
`timescale 1ns/1ps
`default_nettype none
module pct_port_timing_checker (
  input wire logic        i_clk_sys,
  input wire logic        i_rst_n,
  input wire logic        o_phase1,
  input wire logic        o_phase2,
  input wire logic [2:0]  o_state,
  input wire logic        o_cycle_end,
  input wire logic        o_addr_strobe,
  input wire logic        o_fetch,
  input wire logic [7:0]  i_pin_one,
  input wire logic [7:0]  i_pin_three,
  input wire logic        o_timer2_count_in,
  input wire logic        o_timer2_trigger_in,
  input wire logic        o_serial_in,
  input wire logic        o_ext_irq_a,
  input wire logic        o_ext_irq_b,
  input wire logic        o_timer0_count_in,
  input wire logic        o_timer1_count_in,
  input wire logic [31:0] o_pull_down,
  input wire logic [31:0] o_pull_strong,
  input wire logic [31:0] o_pull_weak
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  sequence s_quiet_cycle;
    (!o_cycle_end)[*8] ##1 (!o_cycle_end)[*3];
  endsequence
  sequence s_late_strobe;
    o_addr_strobe[*2] ##1 !o_addr_strobe;
  endsequence
  a_cycle_twelve: assert property (o_cycle_end |=> s_quiet_cycle ##1 o_cycle_end)
    else $error("machine cycle length wrong");
  a_phase_swap: assert property (o_phase1 |-> !o_phase2 ##1 o_phase2 && !o_phase1)
    else $error("phases do not alternate");
  a_state_pair: assert property (o_phase1 |=> $stable(o_state))
    else $error("state lasted one period");
  a_strobe_s4: assert property (o_cycle_end |-> ##8 s_late_strobe)
    else $error("second strobe misplaced");
  a_fetch_strobe: assert property (o_fetch |-> o_addr_strobe && o_phase2)
    else $error("fetch outside strobe phase");
  a_alt_input: assert property (o_serial_in == i_pin_three[0] && o_ext_irq_b == i_pin_three[3])
    else $error("alternate input not the pin");
  a_alt_inputs: assert property (o_ext_irq_a == i_pin_three[2] &&
    o_timer0_count_in == i_pin_three[4] &&
    o_timer1_count_in == i_pin_three[5] &&
    o_timer2_count_in == i_pin_one[0] &&
    o_timer2_trigger_in == i_pin_one[1])
    else $error("timer or irq input not the pin");
  a_weak_idle: assert property ({o_pull_weak[31:24], o_pull_weak[15:8]} == ~{o_pull_down[31:24], o_pull_down[15:8]})
    else $error("weak pull-up wrong");
  a_strong_pulse: assert property ($rose(o_pull_strong[8]) |-> o_state == 3'h0 ##1 o_pull_strong[8] ##1 !o_pull_strong[8])
    else $error("strong pull-up pulse wrong");
  a_pin_at_s1: assert property ($changed(o_pull_down[15:8]) |-> o_state == 3'h0)
    else $error("port pin moved outside state one");
  a_float_zero: assert property (o_pull_weak[7:0] == 8'h00)
    else $error("port zero has a weak pull-up");
endmodule // pct_port_timing_checker
`default_nettype wire

// file: verif/pct_pin_model.sv
// Pad and outside-world model for all four ports
`timescale 1ns/1ps
`default_nettype none
module pct_pin_model (
  input  wire logic        i_clk_sys,
  input  wire logic [31:0] i_pull_down,
  input  wire logic [31:0] i_pull_up,
  input  wire logic [31:0] i_ext_low,
  output logic      [31:0] o_pin
);
  logic [31:0] drift = 32'h0;
  // A floating line must not settle to a friendly value
  always @(posedge i_clk_sys) drift <= ~drift;
  // Any low driver wins; pull-ups only raise an undriven line
  assign o_pin = ~i_pull_down & ~i_ext_low & (i_pull_up | drift);
endmodule // pct_pin_model
`default_nettype wire

// file: verif/pct_port_timing_tb_top.sv
// Self-checking bench for the timing and port block
`timescale 1ns/1ps
`default_nettype none
`include "pct_cfg.svh"
module pct_port_timing_tb_top;
  logic               i_clk_sys = 1'b0, i_rst_n = 1'b0, i_op_start = 1'b0;
  logic               i_op_two_byte = 1'b0, i_op_wide_addr = 1'b0;
  logic               i_wr_req = 1'b0, i_rd_latch = 1'b0, i_rmw = 1'b0;
  logic               i_rd_pin = 1'b0, i_ext_access = 1'b0, ext_dir = 1'b0;
  logic               o_phase2, o_fetch, o_pc_incr, o_op_done;
  logic [2:0]         o_state;
  logic [7:0]         i_code_byte = 8'h00, i_wr_data = 8'h00, o_rd_data;
  logic [7:0]         i_alt_out_one = 8'hff, i_alt_out_three = 8'hff;
  logic [7:0]         o_instr_reg, o_second_byte, ext_dout = 8'h00, ext_din;
  logic [15:0]        i_ext_addr = 16'h0000;
  logic [31:0]        pins, ext_low = 32'h0, o_pull_down, o_pull_strong;
  logic [31:0]        o_pull_hold, o_pull_weak;
  pct_pkg::pct_cls_t  i_op_class = pct_pkg::PCT_ONE_CYC;
  pct_pkg::pct_port_t i_port_sel = pct_pkg::PCT_PORT_ZERO;
  int                 compares = 0, miscompares = 0, ticks = 0;
  int                 clocks, fetches, incs;

  pct_port_timing u_dut (.i_clk_sys, .i_rst_n, .i_op_start, .i_op_class,
    .i_op_two_byte, .i_op_wide_addr, .i_code_byte, .i_port_sel, .i_wr_req,
    .i_wr_data, .i_rd_latch, .i_rmw, .i_rd_pin, .i_ext_access, .i_ext_addr,
    .i_ext_data_out(ext_dout), .i_ext_data_dir(ext_dir), .i_alt_out_one,
    .i_alt_out_three, .i_pin_zero(pins[7:0]), .i_pin_one(pins[15:8]),
    .i_pin_two(pins[23:16]), .i_pin_three(pins[31:24]), .o_phase1(),
    .o_phase2, .o_state, .o_cycle_end(), .o_addr_strobe(), .o_fetch,
    .o_pc_incr, .o_op_done, .o_instr_reg, .o_second_byte, .o_rd_data,
    .o_timer2_count_in(), .o_timer2_trigger_in(), .o_serial_in(),
    .o_ext_irq_a(), .o_ext_irq_b(), .o_timer0_count_in(),
    .o_timer1_count_in(), .o_ext_data_in(ext_din),
    .o_pull_down, .o_pull_strong,
    .o_pull_hold, .o_pull_weak);
  pct_pin_model u_pins (.i_clk_sys, .i_pull_down(o_pull_down),
    .i_pull_up(o_pull_strong | o_pull_hold | o_pull_weak),
    .i_ext_low(ext_low), .o_pin(pins));

  initial forever #20 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) begin
    ticks++;
    if (ticks == 5000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic to_phase(input logic [2:0] s, input logic p2);
    int n;
    n = 0;
    @(negedge i_clk_sys);
    while (!(o_state === s && o_phase2 === p2) && n < 30) begin
      @(negedge i_clk_sys);
      n++;
    end
  endtask
  // Kind 0 reads the latch, 1 the modify-write path, 2 the pins
  task automatic rd(input int kind, input logic [1:0] p, input logic [7:0] e);
    @(negedge i_clk_sys);
    i_port_sel = pct_pkg::pct_port_t'(p);
    {i_rd_pin, i_rmw, i_rd_latch} = 3'h1 << kind;
    @(negedge i_clk_sys);
    {i_rd_pin, i_rmw, i_rd_latch} = 3'h0;
    check(o_rd_data, e);
  endtask
  task automatic run_op(input pct_pkg::pct_cls_t c, input logic two, wr,
                        input logic [1:0] p, input logic [7:0] d);
    to_phase(3'h0, 1'b1);
    i_op_class = c;
    {i_op_two_byte, i_wr_req, i_wr_data} = {two, wr, d};
    i_port_sel = pct_pkg::pct_port_t'(p);
    i_code_byte = 8'h3c;
    i_op_start = 1'b1;
    {clocks, fetches, incs} = '0;
    while (o_op_done !== 1'b1 && clocks < 60) begin
      fetches += o_fetch;
      incs += o_pc_incr;
      @(negedge i_clk_sys);
      i_op_start = 1'b0;
      i_code_byte = 8'hc3;
      clocks++;
    end
    // The write lands on the edge that ends the last state
    @(negedge i_clk_sys);
    i_wr_req = 1'b0;
  endtask

  task automatic t_reset();
    for (int p = 0; p < 4; p++) rd(0, p[1:0], `PCT_PORT_ONES);
    $display("reset test done");
  endtask
  task automatic t_cycles();
    int ncyc [5] = '{1, 1, 2, 2, 4};
    int nfet [5] = '{2, 2, 4, 2, 8};
    for (int k = 0; k < 5; k++) begin
      run_op(pct_pkg::pct_cls_t'(k < 2 ? 0 : k - 1), k == 1, 1'b0, 2'h0, 8'h00);
      check(clocks, 12 * ncyc[k] - 2);
      check(fetches, nfet[k]);
      check(o_instr_reg, 8'h3c);
      if (k < 2) check(incs, k + 1);
      if (k == 1) check(o_second_byte, 8'hc3);
    end
    $display("cycle test done");
  endtask
  task automatic t_write();
    run_op(pct_pkg::PCT_ONE_CYC, 1'b0, 1'b1, 2'h1, 8'h5a);
    // Now in S1P1 of the next cycle: the pin already shows the write
    check(o_pull_down[15:8], 8'ha5);
    to_phase(3'h0, 1'b1);
    check(o_pull_down[15:8], 8'ha5);
    rd(1, 2'h1, 8'h5a);
    rd(2, 2'h1, 8'h5a);
    run_op(pct_pkg::PCT_ONE_CYC, 1'b0, 1'b1, 2'h1, 8'hff);
    check(o_pull_strong[15:8], 8'ha5);
    to_phase(3'h0, 1'b1);
    check(o_pull_strong[15:8], 8'ha5);
    to_phase(3'h1, 1'b1);
    check((o_pull_strong[15:8] | ~o_pull_hold[15:8]) & 8'ha5, 8'h00);
    ext_low[15:8] = 8'h0f;
    rd(2, 2'h1, 8'hf0);
    rd(1, 2'h1, 8'hff);
    check(o_pull_hold[11:8], 4'h0);
    ext_low = 32'h0;
    $display("write test done");
  endtask
  task automatic t_alt();
    run_op(pct_pkg::PCT_ONE_CYC, 1'b0, 1'b1, 2'h3, 8'hf0);
    {i_alt_out_three, i_alt_out_one} = {8'haa, 8'hfe};
    to_phase(3'h1, 1'b1);
    rd(2, 2'h3, 8'ha0);
    rd(2, 2'h1, 8'hfe);
    to_phase(3'h0, 1'b0);
    {i_alt_out_three, i_alt_out_one} = {8'hff, 8'hff};
    $display("alternate test done");
  endtask
  task automatic t_ext();
    run_op(pct_pkg::PCT_ONE_CYC, 1'b0, 1'b1, 2'h0, 8'h00);
    run_op(pct_pkg::PCT_ONE_CYC, 1'b0, 1'b1, 2'h2, 8'h81);
    {i_ext_access, i_op_wide_addr, i_ext_addr} = {2'h3, 16'h3c5a};
    to_phase(3'h3, 1'b1);
    rd(2, 2'h2, 8'h3c);
    check(o_pull_strong[23:16], 8'h3c);
    rd(2, 2'h0, 8'h5a);
    {ext_dir, ext_dout} = {1'b1, 8'hc3};
    rd(2, 2'h0, 8'hc3);
    check(ext_din, 8'hc3);
    check(o_pull_strong[7:0], 8'hc3);
    ext_dir = 1'b0;
    i_op_wide_addr = 1'b0;
    to_phase(3'h3, 1'b1);
    rd(2, 2'h2, 8'h81);
    i_ext_access = 1'b0;
    rd(0, 2'h0, `PCT_PORT_ONES);
    rd(0, 2'h2, 8'h81);
    $display("external bus test done");
  endtask

  task automatic give_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    i_rst_n = 1'b1;
    t_reset();
    t_cycles();
    t_write();
    t_alt();
    t_ext();
    give_verdict();
  end
endmodule // pct_port_timing_tb_top

bind pct_port_timing pct_port_timing_checker u_chk (.i_clk_sys, .i_rst_n,
  .o_phase1, .o_phase2, .o_state, .o_cycle_end, .o_addr_strobe, .o_fetch,
  .i_pin_one, .i_pin_three, .o_timer2_count_in, .o_timer2_trigger_in,
  .o_serial_in, .o_ext_irq_a, .o_ext_irq_b, .o_timer0_count_in,
  .o_timer1_count_in, .o_pull_down, .o_pull_strong, .o_pull_weak);
`default_nettype wire
